// ### pkg/cdid_pkg.sv
// constants and types shared by the character display instruction decoder
package cdid_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int BLINK_HZ = 1;
	localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
	localparam int DD_DEPTH = 80;
	localparam int CG_DEPTH = 64;
	localparam logic [5:0] DD_LINE_LEN = 6'h28;
	localparam logic [6:0] DD_LINE1_BASE = 7'h00;
	localparam logic [6:0] DD_LINE1_LAST = 7'h27;
	localparam logic [6:0] DD_LINE2_BASE = 7'h40;
	localparam logic [6:0] DD_LINE2_LAST = 7'h67;
	localparam logic [7:0] CHAR_SPACE = 8'h20;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [4:0] PIX_ALL = 5'h1F;
	localparam logic [4:0] PIX_NONE = 5'h00;
	localparam logic [2:0] UNDERLINE_ROW = 3'h7;
	localparam logic RS_INSTR = 1'b0;
	localparam logic RS_DATA = 1'b1;
	localparam logic BUSY_VAL = 1'b0;
	// command opcode marker bits: the highest set bit names the command
	localparam int BIT_DD_SET = 7;
	localparam int BIT_CG_SET = 6;
	localparam int BIT_FUNC = 5;
	localparam int BIT_SHIFT = 4;
	localparam int BIT_DISP = 3;
	localparam int BIT_ENTRY = 2;
	localparam int BIT_HOME = 1;
	localparam int BIT_CLEAR = 0;
	// field positions
	localparam int ENT_DIR = 1;
	localparam int ENT_PAN = 0;
	localparam int DSP_ON = 2;
	localparam int DSP_UL = 1;
	localparam int DSP_FL = 0;
	localparam int SH_PAN = 3;
	localparam int SH_DIR = 2;
	localparam int FN_DL = 4;
	localparam int FN_N = 3;
	localparam int FN_BR1 = 1;
	localparam int FN_BR0 = 0;
	// reset values and brightness levels in percent
	localparam logic RST_STEP_DIR = 1'b1;
	localparam logic RST_PAN = 1'b0;
	localparam logic RST_VISIBLE = 1'b0;
	localparam logic RST_UNDERLINE = 1'b0;
	localparam logic RST_FLASH = 1'b0;
	localparam logic RST_BUS_WIDTH = 1'b1;
	localparam logic RST_TWO_ROW = 1'b1;
	localparam logic [1:0] RST_LUM = 2'h0;
	localparam logic [6:0] LUM_100 = 7'h64;
	localparam logic [6:0] LUM_75 = 7'h4B;
	localparam logic [6:0] LUM_50 = 7'h32;
	localparam logic [6:0] LUM_25 = 7'h19;
	typedef enum logic [1:0] {
		NIB_HI = 2'b01,
		NIB_LO = 2'b10
	} cdid_nib_t;
	typedef enum logic [8:0] {
		CMD_NONE = 9'b000000001,
		CMD_CLEAR = 9'b000000010,
		CMD_HOME = 9'b000000100,
		CMD_ENTRY = 9'b000001000,
		CMD_DISP = 9'b000010000,
		CMD_SHIFT = 9'b000100000,
		CMD_FUNC = 9'b001000000,
		CMD_CG_SET = 9'b010000000,
		CMD_DD_SET = 9'b100000000
	} cdid_cmd_t;
endpackage

// ### pkg/cdid_mem_if.sv
// write port, command read port and scan read port of one display memory
`timescale 1ns/100ps
interface cdid_mem_if;
	logic we;
	logic fill;
	logic [6:0] waddr;
	logic [7:0] wdata;
	logic [6:0] raddr_a;
	logic [7:0] rdata_a;
	logic [6:0] raddr_b;
	logic [7:0] rdata_b;
	modport ctrl (output we, fill, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
	modport mem (input we, fill, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

// ### src/cdid_char_mem.sv
// character code memory, two lines of forty cells, one-cycle fill with spaces
`timescale 1ns/100ps
module cdid_char_mem
	import cdid_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	cdid_mem_if.mem m
);
	logic [7:0] mem [DD_DEPTH];
	logic [7:0] next_mem [DD_DEPTH];

	always_comb
	begin
		next_mem = mem;
		if (srst_i || m.fill)
		begin
			for (int i = 0; i < DD_DEPTH; i++)
				next_mem[i] = CHAR_SPACE;
		end
		else if (m.we && (m.waddr < 7'(DD_DEPTH)))
			next_mem[m.waddr] = m.wdata;
	end

	always_ff @(posedge clk_i)
		mem <= next_mem;

	// out-of-range indices read as a space rather than an undriven value
	assign m.rdata_a = (m.raddr_a < 7'(DD_DEPTH)) ? mem[m.raddr_a] : CHAR_SPACE;
	assign m.rdata_b = (m.raddr_b < 7'(DD_DEPTH)) ? mem[m.raddr_b] : CHAR_SPACE;
endmodule // cdid_char_mem

// ### src/cdid_glyph_mem.sv
// user glyph pattern memory, eight glyphs of eight rows
`timescale 1ns/100ps
module cdid_glyph_mem
	import cdid_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	cdid_mem_if.mem m
);
	logic [7:0] mem [CG_DEPTH];
	logic [7:0] next_mem [CG_DEPTH];

	always_comb
	begin
		next_mem = mem;
		if (srst_i)
		begin
			for (int i = 0; i < CG_DEPTH; i++)
				next_mem[i] = BYTE_ZERO;
		end
		else if (m.we)
			next_mem[m.waddr[5:0]] = m.wdata;
	end

	always_ff @(posedge clk_i)
		mem <= next_mem;

	assign m.rdata_a = mem[m.raddr_a[5:0]];
	assign m.rdata_b = mem[m.raddr_b[5:0]];
endmodule // cdid_glyph_mem

// ### src/cdid_top.sv
// instruction decoder, cursor counter and display state of the character display
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module cdid_top
	import cdid_pkg::*;
#(
	parameter int unsigned BLINK_HALF = cdid_pkg::BLINK_HALF_CYCLES
)
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic instr_data_select_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [4:0] scan_col_i,
	input wire logic scan_line_i,
	input wire logic [2:0] scan_prow_i,
	output logic [7:0] cell_code_o,
	output logic [4:0] pix_o,
	output logic pix_final_o,
	output logic [6:0] lum_pct_o,
	output logic bus_width_sel_o,
	output logic two_row_sel_o
);
	import cdid_pkg::*;

	function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up, input logic cg);
		logic [6:0] r;
		r = a;
		if (cg)
			r = {1'b0, up ? a[5:0] + 6'h1 : a[5:0] - 6'h1};
		else if (up)
			r = (a == DD_LINE1_LAST) ? DD_LINE2_BASE : (a == DD_LINE2_LAST) ? DD_LINE1_BASE : a + 7'h1;
		else
			r = (a == DD_LINE1_BASE) ? DD_LINE2_LAST : (a == DD_LINE2_BASE) ? DD_LINE1_LAST : a - 7'h1;
		return r;
	endfunction

	function automatic logic dd_valid(input logic [6:0] a);
		return a[5:0] < DD_LINE_LEN;
	endfunction

	// line two sits right after line one in the flat cell array
	function automatic logic [6:0] dd_index(input logic [6:0] a);
		return a[6] ? {1'b0, a[5:0]} + {1'b0, DD_LINE_LEN} : {1'b0, a[5:0]};
	endfunction

	function automatic logic [5:0] ofs_step(input logic [5:0] o, input logic left);
		logic [5:0] r;
		if (left)
			r = (o == DD_LINE_LEN - 6'h1) ? 6'h0 : o + 6'h1;
		else
			r = (o == 6'h0) ? DD_LINE_LEN - 6'h1 : o - 6'h1;
		return r;
	endfunction

	function automatic cdid_cmd_t cmd_decode(input logic [7:0] b);
		cdid_cmd_t c;
		c = CMD_NONE;
		if (b[BIT_DD_SET])
			c = CMD_DD_SET;
		else if (b[BIT_CG_SET])
			c = CMD_CG_SET;
		else if (b[BIT_FUNC])
			c = CMD_FUNC;
		else if (b[BIT_SHIFT])
			c = CMD_SHIFT;
		else if (b[BIT_DISP])
			c = CMD_DISP;
		else if (b[BIT_ENTRY])
			c = CMD_ENTRY;
		else if (b[BIT_HOME])
			c = CMD_HOME;
		else if (b[BIT_CLEAR])
			c = CMD_CLEAR;
		return c;
	endfunction

	cdid_mem_if dd_bus();
	cdid_mem_if cg_bus();

	cdid_char_mem u_char_mem (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.m(dd_bus.mem)
	);

	cdid_glyph_mem u_glyph_mem (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.m(cg_bus.mem)
	);

	logic [6:0] ac;
	logic cg_sel;
	logic step_direction;
	logic window_pan_on;
	logic screen_visible;
	logic underline_on;
	logic flash_cursor;
	logic bus_width_sel;
	logic two_row_sel;
	logic luminance_level_hi;
	logic luminance_level_lo;
	logic [5:0] shift_ofs;
	cdid_nib_t nib_state;
	logic [3:0] nib_hi;
	logic [6:0] next_ac;
	logic next_cg_sel;
	logic next_step_direction;
	logic next_window_pan_on;
	logic next_screen_visible;
	logic next_underline_on;
	logic next_flash_cursor;
	logic next_bus_width_sel;
	logic next_two_row_sel;
	logic next_luminance_level_hi;
	logic next_luminance_level_lo;
	logic [5:0] next_shift_ofs;
	cdid_nib_t next_nib_state;
	logic [3:0] next_nib_hi;
	logic [7:0] next_rdata;
	logic byte_done;
	logic [7:0] byte_val;
	logic [7:0] rd_val;

	// host transfers; a byte is complete on one strobe in 8-bit mode, on two in 4-bit
	always_comb
	begin
		next_nib_state = nib_state;
		next_nib_hi = nib_hi;
		byte_done = 1'b0;
		byte_val = wdata_i;
		if (bus_width_sel)
		begin
			byte_done = wr_i | rd_i;
			next_nib_state = NIB_HI;
		end
		else if (wr_i | rd_i)
		begin
			case (nib_state)
				NIB_HI:
				begin
					next_nib_hi = wdata_i[7:4];
					next_nib_state = NIB_LO;
				end
				NIB_LO:
				begin
					byte_done = 1'b1;
					byte_val = {nib_hi, wdata_i[7:4]};
					next_nib_state = NIB_HI;
				end
				default:
					next_nib_state = NIB_HI;
			endcase
		end
	end

	// read answers; the busy flag is constant since nothing ever takes longer than a clock
	always_comb
	begin
		dd_bus.raddr_a = dd_index(ac);
		cg_bus.raddr_a = {1'b0, ac[5:0]};
		if (instr_data_select_i == RS_DATA)
			rd_val = cg_sel ? cg_bus.rdata_a : dd_bus.rdata_a;
		else
			rd_val = {BUSY_VAL, ac};
		next_rdata = BYTE_ZERO;
		if (rd_i)
		begin
			if (bus_width_sel)
				next_rdata = rd_val;
			else if (nib_state == NIB_HI)
				next_rdata = {rd_val[7:4], NIB_ZERO};
			else
				next_rdata = {rd_val[3:0], NIB_ZERO};
		end
	end

	// command execution, all in the cycle the byte completes
	always_comb
	begin
		next_ac = ac;
		next_cg_sel = cg_sel;
		next_step_direction = step_direction;
		next_window_pan_on = window_pan_on;
		next_screen_visible = screen_visible;
		next_underline_on = underline_on;
		next_flash_cursor = flash_cursor;
		next_bus_width_sel = bus_width_sel;
		next_two_row_sel = two_row_sel;
		next_luminance_level_hi = luminance_level_hi;
		next_luminance_level_lo = luminance_level_lo;
		next_shift_ofs = shift_ofs;
		dd_bus.we = 1'b0;
		dd_bus.fill = 1'b0;
		dd_bus.waddr = dd_index(ac);
		dd_bus.wdata = byte_val;
		cg_bus.we = 1'b0;
		cg_bus.fill = 1'b0;
		cg_bus.waddr = {1'b0, ac[5:0]};
		cg_bus.wdata = byte_val;
		if (byte_done && instr_data_select_i == RS_DATA)
		begin
			if (wr_i)
			begin
				if (cg_sel)
					cg_bus.we = 1'b1;
				else
				begin
					dd_bus.we = dd_valid(ac);
					if (window_pan_on)
						next_shift_ofs = ofs_step(shift_ofs, step_direction);
				end
			end
			next_ac = ac_step(ac, step_direction, cg_sel);
		end
		else if (byte_done && wr_i)
		begin
			// instruction reads fall through untouched
			case (cmd_decode(byte_val))
				CMD_CLEAR:
				begin
					dd_bus.fill = 1'b1;
					next_ac = DD_LINE1_BASE;
					next_cg_sel = 1'b0;
					next_shift_ofs = 6'h0;
					next_step_direction = 1'b1;
				end
				CMD_HOME:
				begin
					next_ac = DD_LINE1_BASE;
					next_cg_sel = 1'b0;
					next_shift_ofs = 6'h0;
				end
				CMD_ENTRY:
				begin
					next_step_direction = byte_val[ENT_DIR];
					next_window_pan_on = byte_val[ENT_PAN];
				end
				CMD_DISP:
				begin
					next_screen_visible = byte_val[DSP_ON];
					next_underline_on = byte_val[DSP_UL];
					next_flash_cursor = byte_val[DSP_FL];
				end
				CMD_SHIFT:
				begin
					// the counter steps in char space even when it held a glyph address
					next_ac = ac_step(ac, byte_val[SH_DIR], 1'b0);
					next_cg_sel = 1'b0;
					if (byte_val[SH_PAN])
						next_shift_ofs = ofs_step(shift_ofs, !byte_val[SH_DIR]);
				end
				CMD_FUNC:
				begin
					next_bus_width_sel = byte_val[FN_DL];
					next_two_row_sel = byte_val[FN_N];
					next_luminance_level_hi = byte_val[FN_BR1];
					next_luminance_level_lo = byte_val[FN_BR0];
				end
				CMD_CG_SET:
				begin
					next_ac = {1'b0, byte_val[5:0]};
					next_cg_sel = 1'b1;
				end
				CMD_DD_SET:
				begin
					next_ac = byte_val[6:0];
					next_cg_sel = 1'b0;
				end
				default:
					next_ac = ac;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ac <= DD_LINE1_BASE;
			cg_sel <= 1'b0;
			shift_ofs <= 6'h0;
			step_direction <= RST_STEP_DIR;
			window_pan_on <= RST_PAN;
			screen_visible <= RST_VISIBLE;
			underline_on <= RST_UNDERLINE;
			flash_cursor <= RST_FLASH;
			bus_width_sel <= RST_BUS_WIDTH;
			two_row_sel <= RST_TWO_ROW;
			luminance_level_hi <= RST_LUM[1];
			luminance_level_lo <= RST_LUM[0];
			nib_state <= NIB_HI;
			nib_hi <= NIB_ZERO;
			rdata_o <= BYTE_ZERO;
		end
		else
		begin
			ac <= next_ac;
			cg_sel <= next_cg_sel;
			shift_ofs <= next_shift_ofs;
			step_direction <= next_step_direction;
			window_pan_on <= next_window_pan_on;
			screen_visible <= next_screen_visible;
			underline_on <= next_underline_on;
			flash_cursor <= next_flash_cursor;
			bus_width_sel <= next_bus_width_sel;
			two_row_sel <= next_two_row_sel;
			luminance_level_hi <= next_luminance_level_hi;
			luminance_level_lo <= next_luminance_level_lo;
			nib_state <= next_nib_state;
			nib_hi <= next_nib_hi;
			rdata_o <= next_rdata;
		end
	end

	assign bus_width_sel_o = bus_width_sel;
	assign two_row_sel_o = two_row_sel;

	// blink timebase runs freely so the phase never jumps when flashing is enabled
	logic [23:0] blink_cnt;
	logic blink_on;
	logic [23:0] next_blink_cnt;
	logic next_blink_on;

	always_comb
	begin
		next_blink_cnt = blink_cnt + 24'h1;
		next_blink_on = blink_on;
		if (blink_cnt == 24'(BLINK_HALF - 1))
		begin
			next_blink_cnt = 24'h0;
			next_blink_on = !blink_on;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			blink_cnt <= 24'h0;
			blink_on <= 1'b0;
		end
		else
		begin
			blink_cnt <= next_blink_cnt;
			blink_on <= next_blink_on;
		end
	end

	// scan lookup: cell at column and line, after the display shift
	logic [6:0] scan_pos;
	logic [6:0] scan_idx;
	logic cursor_here;
	logic [7:0] next_cell_code;
	logic [4:0] next_pix;
	logic next_pix_final;
	logic [6:0] next_lum_pct;

	always_comb
	begin
		scan_pos = {2'h0, scan_col_i} + {1'b0, shift_ofs};
		if (scan_pos >= {1'b0, DD_LINE_LEN})
			scan_pos = scan_pos - {1'b0, DD_LINE_LEN};
		scan_idx = scan_line_i ? scan_pos + {1'b0, DD_LINE_LEN} : scan_pos;
		dd_bus.raddr_b = scan_idx;
		cg_bus.raddr_b = {1'b0, dd_bus.rdata_b[2:0], scan_prow_i};
		cursor_here = !cg_sel && dd_valid(ac) && (dd_index(ac) == scan_idx);
		next_cell_code = dd_bus.rdata_b;
		next_pix = PIX_NONE;
		next_pix_final = 1'b1;
		if (!screen_visible)
			next_pix = PIX_NONE;
		else if (cursor_here && flash_cursor && blink_on)
			next_pix = PIX_ALL;
		else if (cursor_here && underline_on && scan_prow_i == UNDERLINE_ROW)
			next_pix = PIX_ALL;
		else if (dd_bus.rdata_b[7:4] == NIB_ZERO)
			next_pix = cg_bus.rdata_b[4:0];
		else
			next_pix_final = 1'b0;
		case ({luminance_level_hi, luminance_level_lo})
			2'h0: next_lum_pct = LUM_100;
			2'h1: next_lum_pct = LUM_75;
			2'h2: next_lum_pct = LUM_50;
			default: next_lum_pct = LUM_25;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			cell_code_o <= CHAR_SPACE;
			pix_o <= PIX_NONE;
			pix_final_o <= 1'b1;
			lum_pct_o <= LUM_100;
		end
		else
		begin
			cell_code_o <= next_cell_code;
			pix_o <= next_pix;
			pix_final_o <= next_pix_final;
			lum_pct_o <= next_lum_pct;
		end
	end
endmodule // cdid_top

// ### verification/cdid_monitor.sv
// port checker for the character display instruction decoder
`timescale 1ns/100ps
module cdid_monitor
	import cdid_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic instr_data_select_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [4:0] pix_o,
	input wire logic pix_final_o,
	input wire logic [6:0] lum_pct_o,
	input wire logic bus_width_sel_o,
	input wire logic two_row_sel_o
);
	// only whole-byte commands are judged; a 4-bit pair cannot be decoded from one strobe
	logic ins8;
	logic fn8;
	assign ins8 = wr_i && instr_data_select_i == RS_INSTR && bus_width_sel_o;
	assign fn8 = ins8 && wdata_i[7:5] == 3'b001;
	function automatic logic [6:0] lum_of(input logic [1:0] b);
		return b == 2'h0 ? 7'h64 : b == 2'h1 ? 7'h4B : b == 2'h2 ? 7'h32 : 7'h19;
	endfunction
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data seen outside a read answer");
	chk_busy_low: assert property (rd_i && instr_data_select_i == RS_INSTR && bus_width_sel_o |=> !rdata_o[7])
		else $error("busy bit read as one");
	// brightness output is registered behind the stored bits, so it follows a function set by two edges
	chk_lum_map: assert property (fn8 |-> ##2 lum_pct_o == lum_of($past(wdata_i[1:0], 2)))
		else $error("brightness does not follow function set");
	chk_lum_legal: assert property (lum_pct_o inside {7'h64, 7'h4B, 7'h32, 7'h19})
		else $error("brightness outside the four levels");
	chk_lum_cause: assert property ($changed(lum_pct_o) |-> $past(wr_i, 2) && !$past(instr_data_select_i, 2))
		else $error("brightness changed without a command");
	chk_width_set: assert property (fn8 |=> bus_width_sel_o == $past(wdata_i[4]))
		else $error("bus width does not follow function set");
	chk_width_cause: assert property ($changed(bus_width_sel_o) |-> $past(wr_i))
		else $error("bus width changed without a write");
	chk_rows_set: assert property (fn8 |=> two_row_sel_o == $past(wdata_i[3]))
		else $error("row count does not follow function set");
	chk_blank_off: assert property (ins8 && wdata_i[7:3] == 5'h01 && !wdata_i[2] |-> ##2 pix_final_o && pix_o == 5'h00)
		else $error("display not blanked after display off");
endmodule // cdid_monitor
bind cdid_top cdid_monitor u_cdid_monitor (
	.clk_i(clk_i), .srst_i(srst_i), .instr_data_select_i(instr_data_select_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pix_o(pix_o),
	.pix_final_o(pix_final_o), .lum_pct_o(lum_pct_o), .bus_width_sel_o(bus_width_sel_o),
	.two_row_sel_o(two_row_sel_o)
);

// ### verification/cdid_host_model.sv
// host processor model driving the command strobes
`timescale 1ns/100ps
module cdid_host_model
(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic sel_o,
	output logic [7:0] data_o,
	output logic wr_o,
	output logic rd_o
);
	initial
	begin
		sel_o = 1'b0;
		data_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// never polls busy: strobes may come on any later edge
	task automatic put(input logic s, input logic [7:0] b);
		@(posedge clk_i);
		sel_o <= s;
		data_o <= b;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// released bus shows the inverse so a stale value never matches by luck
		sel_o <= ~s;
		data_o <= ~b;
		#1;
	endtask
	task automatic get(input logic s, output logic [7:0] b);
		@(posedge clk_i);
		sel_o <= s;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		sel_o <= ~s;
		#1;
		b = rdata_i;
	endtask
endmodule // cdid_host_model

// ### verification/cdid_tb_top.sv
// testbench for the character display instruction decoder
`timescale 1ns/100ps
module cdid_tb_top;
	logic clk_i;
	logic srst_i;
	logic sel;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata_o;
	logic [4:0] scan_col_i;
	logic scan_line_i;
	logic [2:0] scan_prow_i;
	logic [7:0] cell_code_o;
	logic [4:0] pix_o;
	logic pix_final_o;
	logic [6:0] lum_pct_o;
	logic bus_width_sel_o;
	logic two_row_sel_o;
	int fails;
	int comparisons;
	int n;
	logic [6:0] lum_tab [4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	cdid_top #(.BLINK_HALF(8)) u_cdid_top (.clk_i(clk_i), .srst_i(srst_i), .instr_data_select_i(sel),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .scan_col_i(scan_col_i),
		.scan_line_i(scan_line_i), .scan_prow_i(scan_prow_i), .cell_code_o(cell_code_o), .pix_o(pix_o),
		.pix_final_o(pix_final_o), .lum_pct_o(lum_pct_o), .bus_width_sel_o(bus_width_sel_o),
		.two_row_sel_o(two_row_sel_o));
	cdid_host_model u_cdid_host_model (.clk_i(clk_i), .rdata_i(rdata_o), .sel_o(sel), .data_o(wdata),
		.wr_o(wr), .rd_o(rd));
	task automatic stop_test();
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic s, input logic [7:0] b);
		u_cdid_host_model.put(s, b);
	endtask
	task automatic r(input logic s, input logic [7:0] exp);
		logic [7:0] d;
		u_cdid_host_model.get(s, d);
		chk(d, exp);
	endtask
	// scan one cell row; outputs are registered one cycle behind the scan inputs
	task automatic sc(input logic [4:0] c, input logic [2:0] p);
		@(posedge clk_i);
		scan_col_i <= c;
		scan_prow_i <= p;
		@(posedge clk_i);
		#1;
	endtask
	initial
	begin
		repeat (4000) @(posedge clk_i);
		fails++;
		stop_test();
	end
	initial
	begin
		srst_i = 1'b1;
		scan_col_i = 5'h00;
		scan_line_i = 1'b0;
		scan_prow_i = 3'h0;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		chk({1'b0, lum_pct_o}, 8'h64);
		chk({6'h00, bus_width_sel_o, two_row_sel_o}, 8'h03);
		r(1'b0, 8'h00);
		w(1'b0, 8'h08);
		sc(5'h00, 3'h0);
		chk({2'h0, pix_final_o, pix_o}, 8'h20);
		w(1'b1, 8'h41);
		r(1'b0, 8'h01);
		w(1'b0, 8'h80);
		r(1'b1, 8'h41);
		r(1'b0, 8'h01);
		w(1'b0, 8'h04);
		w(1'b0, 8'h85);
		w(1'b1, 8'h42);
		r(1'b0, 8'h04);
		r(1'b1, 8'h20);
		w(1'b0, 8'h06);
		r(1'b0, 8'h03);
		w(1'b0, 8'h02);
		r(1'b0, 8'h00);
		w(1'b0, 8'h14);
		r(1'b0, 8'h01);
		w(1'b0, 8'h10);
		r(1'b0, 8'h00);
		w(1'b0, 8'h48);
		w(1'b1, 8'h1F);
		r(1'b0, 8'h09);
		w(1'b0, 8'h48);
		r(1'b1, 8'h1F);
		w(1'b0, 8'h4B);
		w(1'b0, 8'h10);
		r(1'b0, 8'h0A);
		r(1'b1, 8'h20);
		for (int i = 0; i < 4; i++)
		begin
			w(1'b0, 8'h38 | 8'(i));
			// brightness output lags the stored bits by one register
			@(posedge clk_i);
			#1;
			chk({1'b0, lum_pct_o}, {1'b0, lum_tab[i]});
			chk({6'h00, bus_width_sel_o, two_row_sel_o}, 8'h03);
		end
		w(1'b0, 8'hA7);
		w(1'b1, 8'h5A);
		w(1'b0, 8'h1C);
		sc(5'h00, 3'h0);
		chk(cell_code_o, 8'h5A);
		w(1'b0, 8'h02);
		sc(5'h00, 3'h0);
		chk(cell_code_o, 8'h41);
		w(1'b0, 8'h0E);
		sc(5'h00, 3'h7);
		chk({2'h0, pix_final_o, pix_o}, 8'h3F);
		sc(5'h00, 3'h0);
		chk({7'h00, pix_final_o}, 8'h00);
		w(1'b0, 8'h0D);
		n = 0;
		// two full blink periods hold exactly two on-halves whatever the phase
		repeat (32)
		begin
			@(posedge clk_i);
			#1;
			if (pix_final_o === 1'b1 && pix_o === 5'h1F)
				n++;
		end
		chk(8'(n), 8'h10);
		w(1'b0, 8'h41);
		w(1'b1, 8'h15);
		w(1'b0, 8'h81);
		w(1'b1, 8'h00);
		w(1'b0, 8'h0C);
		sc(5'h01, 3'h1);
		chk({2'h0, pix_final_o, pix_o}, 8'h35);
		w(1'b0, 8'h04);
		w(1'b0, 8'h01);
		r(1'b1, 8'h20);
		r(1'b0, 8'h01);
		w(1'b0, 8'h48);
		r(1'b1, 8'h1F);
		w(1'b0, 8'h28);
		chk({7'h00, bus_width_sel_o}, 8'h00);
		// 4-bit mode: high nibble first, each on the upper lines
		w(1'b0, 8'h80);
		w(1'b0, 8'h00);
		w(1'b1, 8'h50);
		w(1'b1, 8'h60);
		w(1'b0, 8'h80);
		w(1'b0, 8'h00);
		r(1'b1, 8'h50);
		r(1'b1, 8'h60);
		r(1'b0, 8'h00);
		r(1'b0, 8'h10);
		w(1'b0, 8'h30);
		w(1'b0, 8'h80);
		chk({7'h00, bus_width_sel_o}, 8'h01);
		w(1'b0, 8'h80);
		r(1'b1, 8'h56);
		// second reset in mid-run with the step direction turned around first
		w(1'b0, 8'h04);
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		r(1'b1, 8'h20);
		r(1'b0, 8'h01);
		sc(5'h00, 3'h0);
		chk({2'h0, pix_final_o, pix_o}, 8'h20);
		// entry-mode panning after char writes, and none after reads
		w(1'b1, 8'h34);
		w(1'b0, 8'h07);
		w(1'b0, 8'h80);
		w(1'b1, 8'h33);
		sc(5'h00, 3'h0);
		chk(cell_code_o, 8'h34);
		w(1'b0, 8'h05);
		w(1'b1, 8'h35);
		sc(5'h00, 3'h0);
		chk(cell_code_o, 8'h33);
		r(1'b1, 8'h33);
		sc(5'h00, 3'h0);
		chk(cell_code_o, 8'h33);
		r(1'b0, 8'h67);
		stop_test();
	end
endmodule // cdid_tb_top
